// file: src/rpmc_pkg.sv
// package for the reset and power mode controller: register map, fields, states, timing
// assumes an 8-bit special function register bus and one 250 MHz system clock
package rpmc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] PMC_ADDR     = 8'h87;  // power_mode_control
  localparam logic [7:0] SMC_ADDR     = 8'hFF;  // supply_monitor_control
  localparam logic [7:0] RSR_ADDR     = 8'hEF;  // reset_source_register
  localparam logic [7:0] PMC_RESET    = 8'h00;
  localparam logic [7:0] PORT_RST_VAL = 8'hFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [3:0] WDT_DIV_RST  = 4'hC;   // system clock divided by 12

  // ==========================================================
  // field positions
  localparam int PMC_IDLE_BIT  = 0;
  localparam int PMC_STOP_BIT  = 1;
  localparam int PMC_GF_LSB    = 2;
  localparam int PMC_GF_W      = 6;
  localparam int SMC_EN_BIT    = 7;
  localparam int SMC_STAT_BIT  = 6;
  localparam int RSR_PORF_BIT  = 1;
  localparam int RSR_SWR_BIT   = 4;

  // ==========================================================
  // timing
  localparam int CLK_MHZ          = 250;
  localparam int POR_DELAY_US     = 300;  // 0.3 ms
  localparam int POR_DELAY_CYCLES = POR_DELAY_US * CLK_MHZ;

  // ==========================================================
  // controller states, gray along the power-up path
  typedef enum logic [2:0] {
    RPMC_POR_HOLD  = 3'b000,
    RPMC_POR_DELAY = 3'b001,
    RPMC_RUN       = 3'b011,
    RPMC_IDLE      = 3'b010,
    RPMC_STOP      = 3'b110,
    RPMC_RST_HOLD  = 3'b111
  } rpmc_state_t;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpmc_sfr_req_t;

endpackage : rpmc_pkg

// file: src/rpmc_delay.sv
// loadable down counter used for the power-on release delay
// assumes load and count come from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module rpmc_delay #(
  parameter int W = 17
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  logic [W-1:0] cnt_r;

  // ==========================================================
  // count down to zero after a load
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_r <= '0;
    end else if (i_load) begin
      cnt_r <= i_count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // done only when not being reloaded
  assign o_done = (cnt_r == '0) && !i_load;
endmodule : rpmc_delay
`default_nettype wire

// file: src/rpmc_ctrl.sv
// reset and power mode controller: mode register, reset sequencing, supply monitor reset
// assumes i_reset is the power-on detector, all inputs synchronous to i_ref_clk
// Notes on behaviour
// - mode register at 0x87, six free flags
// - stop bit halts oscillator, reads zero
// - idle bit gates processor clock, reads zero
// - enabled interrupt or reset ends idle
// - only a reset ends stop mode
// - reset halts cpu, resets registers, ports, interrupts
// - data memory kept except across power-up, stack pointer reinitialised
// - port latches 0xFF open-drain, pull-ups on
// - pin driven low for power resets only
// - exit clears pc, internal oscillator, vector 0
// - watchdog enabled at divide by 12
// - power-up waits for supply then delay
// - power flag set by power resets only
// - monitor enable reset only by power-on
// - low supply holds reset until recovery
// - monitor reset release has no delay
`timescale 1ns/1ns
`default_nettype none
module rpmc_ctrl #(
  parameter int POR_DELAY = rpmc_pkg::POR_DELAY_CYCLES
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  input  wire rpmc_pkg::rpmc_sfr_req_t i_sfr,
  output logic [7:0]                  o_sfr_rdata,
  input  wire logic                   i_supply_above,
  input  wire logic                   i_rst_pin_i,
  input  wire logic                   i_other_reset,
  input  wire logic                   i_irq_pending,
  output logic                        o_rst_pin_o,
  output logic                        o_rst_pin_oe,
  output logic                        o_sys_reset,
  output logic                        o_cpu_clk_en,
  output logic                        o_osc_en,
  output logic                        o_periph_clk_en,
  output logic                        o_int_timer_dis,
  output logic                        o_pc_load,
  output logic [15:0]                 o_pc_vector,
  output logic                        o_sp_reinit,
  output logic                        o_ram_keep,
  output logic                        o_clk_sel_int,
  output logic [7:0]                  o_port_latch,
  output logic                        o_port_od,
  output logic                        o_weak_pullup,
  output logic                        o_wdt_enable,
  output logic [3:0]                  o_wdt_div
);
  localparam int DW = $clog2(POR_DELAY + 1);

  rpmc_pkg::rpmc_state_t state_r, state_nxt;
  logic [rpmc_pkg::PMC_GF_W-1:0] gflags_r;
  logic mon_en_r, mon_sel_r, por_flag_r, mon_cause_r, sw_req_r;
  logic pin_req, mon_req, any_req, dly_load, dly_done, exit_rst;
  logic wr_pmc, wr_smc, wr_rsr;

  // ==========================================================
  // register decode
  assign wr_pmc = i_sfr.wr && (i_sfr.addr == rpmc_pkg::PMC_ADDR);
  assign wr_smc = i_sfr.wr && (i_sfr.addr == rpmc_pkg::SMC_ADDR);
  assign wr_rsr = i_sfr.wr && (i_sfr.addr == rpmc_pkg::RSR_ADDR);

  // ==========================================================
  // reset requests; the monitor counts only when enabled and selected
  assign pin_req = !i_rst_pin_i;
  assign mon_req = mon_en_r && mon_sel_r && !i_supply_above;
  assign any_req = pin_req || mon_req || i_other_reset || sw_req_r;
  // a supply drop in the same cycle as the delay end sends us back to hold, not out
  assign exit_rst = ((state_r == rpmc_pkg::RPMC_POR_DELAY) && i_supply_above && dly_done)
                 || ((state_r == rpmc_pkg::RPMC_RST_HOLD) && !any_req);

  // ==========================================================
  // power-on delay counter
  assign dly_load = (state_r == rpmc_pkg::RPMC_POR_HOLD);
  rpmc_delay #(.W(DW)) u_por_delay (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_load    (dly_load),
    .i_count   (DW'(POR_DELAY)),
    .o_done    (dly_done)
  );

  // ==========================================================
  // state sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rpmc_pkg::RPMC_POR_HOLD: begin
        if (i_supply_above) state_nxt = rpmc_pkg::RPMC_POR_DELAY;
      end
      rpmc_pkg::RPMC_POR_DELAY: begin
        if (!i_supply_above) state_nxt = rpmc_pkg::RPMC_POR_HOLD;
        else if (dly_done) state_nxt = rpmc_pkg::RPMC_RUN;
      end
      rpmc_pkg::RPMC_RUN: begin
        if (any_req) state_nxt = rpmc_pkg::RPMC_RST_HOLD;
        else if (wr_pmc && i_sfr.wdata[rpmc_pkg::PMC_STOP_BIT]) state_nxt = rpmc_pkg::RPMC_STOP;
        else if (wr_pmc && i_sfr.wdata[rpmc_pkg::PMC_IDLE_BIT]) state_nxt = rpmc_pkg::RPMC_IDLE;
      end
      rpmc_pkg::RPMC_IDLE: begin
        if (any_req) state_nxt = rpmc_pkg::RPMC_RST_HOLD;
        else if (i_irq_pending) state_nxt = rpmc_pkg::RPMC_RUN;
      end
      rpmc_pkg::RPMC_STOP: begin
        if (any_req) state_nxt = rpmc_pkg::RPMC_RST_HOLD;
      end
      rpmc_pkg::RPMC_RST_HOLD: begin
        // monitor release goes straight to run, no power-on delay
        if (!any_req) state_nxt = rpmc_pkg::RPMC_RUN;
      end
      default: state_nxt = rpmc_pkg::RPMC_POR_HOLD;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) state_r <= rpmc_pkg::RPMC_POR_HOLD;
    else state_r <= state_nxt;
  end

  // ==========================================================
  // software reset request; held until the first hold cycle so the hold state sees it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || state_r == rpmc_pkg::RPMC_RST_HOLD) sw_req_r <= 1'b0;
    else if (wr_rsr && i_sfr.wdata[rpmc_pkg::RSR_SWR_BIT]) sw_req_r <= 1'b1;
  end

  // ==========================================================
  // remember whether the supply monitor caused the current reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) mon_cause_r <= 1'b0;
    else if (state_r != rpmc_pkg::RPMC_RST_HOLD && state_nxt == rpmc_pkg::RPMC_RST_HOLD) mon_cause_r <= mon_req;
    else if (state_r == rpmc_pkg::RPMC_RST_HOLD && mon_req) mon_cause_r <= 1'b1;
  end

  // ==========================================================
  // power flag: set on exit from power resets, cleared by the others
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) por_flag_r <= 1'b0;
    else if (exit_rst) por_flag_r <= (state_r == rpmc_pkg::RPMC_POR_DELAY) || mon_cause_r;
  end

  // ==========================================================
  // monitor enable: only power-on resets it, so software resets keep it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) mon_en_r <= 1'b1;
    else if (wr_smc) mon_en_r <= i_sfr.wdata[rpmc_pkg::SMC_EN_BIT];
  end

  // monitor selection as reset source, written through the power flag bit
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) mon_sel_r <= 1'b1;
    else if (wr_rsr) mon_sel_r <= i_sfr.wdata[rpmc_pkg::RSR_PORF_BIT];
  end

  // ==========================================================
  // general flags, reset with every system reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || o_sys_reset) gflags_r <= rpmc_pkg::PMC_RESET[rpmc_pkg::PMC_GF_LSB +: rpmc_pkg::PMC_GF_W];
    else if (wr_pmc) gflags_r <= i_sfr.wdata[rpmc_pkg::PMC_GF_LSB +: rpmc_pkg::PMC_GF_W];
  end

  // ==========================================================
  // read data; mode select bits always read as zero
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr.rd) begin
      case (i_sfr.addr)
        rpmc_pkg::PMC_ADDR: o_sfr_rdata <= {gflags_r, 2'b00};
        rpmc_pkg::SMC_ADDR: o_sfr_rdata <= {mon_en_r, i_supply_above, 6'h00};
        rpmc_pkg::RSR_ADDR: o_sfr_rdata <= {6'h00, por_flag_r, 1'b0};
        default:            o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // reset effects and clock gating, all registered from next state
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_sys_reset     <= 1'b1;
      o_cpu_clk_en    <= 1'b0;
      o_osc_en        <= 1'b1;
      o_periph_clk_en <= 1'b0;
      o_int_timer_dis <= 1'b1;
      o_rst_pin_oe    <= 1'b1;
    end else begin
      o_sys_reset     <= state_nxt inside {rpmc_pkg::RPMC_POR_HOLD, rpmc_pkg::RPMC_POR_DELAY,
                                           rpmc_pkg::RPMC_RST_HOLD};
      o_cpu_clk_en    <= (state_nxt == rpmc_pkg::RPMC_RUN);
      o_osc_en        <= (state_nxt != rpmc_pkg::RPMC_STOP);
      o_periph_clk_en <= state_nxt inside {rpmc_pkg::RPMC_RUN, rpmc_pkg::RPMC_IDLE};
      o_int_timer_dis <= state_nxt inside {rpmc_pkg::RPMC_POR_HOLD, rpmc_pkg::RPMC_POR_DELAY,
                                           rpmc_pkg::RPMC_RST_HOLD, rpmc_pkg::RPMC_STOP};
      // pin is driven only by power-up and supply monitor resets
      // the cause of an earlier reset must not drive the pin on a new entry
      o_rst_pin_oe    <= (state_nxt inside {rpmc_pkg::RPMC_POR_HOLD, rpmc_pkg::RPMC_POR_DELAY})
                      || (state_nxt == rpmc_pkg::RPMC_RST_HOLD
                          && (mon_req || (state_r == rpmc_pkg::RPMC_RST_HOLD && mon_cause_r)));
    end
  end

  // ==========================================================
  // exit actions: pc load and watchdog pulse one cycle as reset releases, stack reinit trails reset by one cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pc_load    <= 1'b0;
      o_sp_reinit  <= 1'b1;
      o_wdt_enable <= 1'b0;
    end else begin
      o_pc_load    <= exit_rst;
      o_sp_reinit  <= o_sys_reset;
      o_wdt_enable <= exit_rst;
    end
  end

  // ==========================================================
  // fixed levels, open-drain follows reset; ram is preserved except across power-up
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ram_keep    <= 1'b0;
      o_rst_pin_o   <= 1'b0;
      o_pc_vector   <= rpmc_pkg::RESET_VECTOR;
      o_clk_sel_int <= 1'b1;
      o_port_latch  <= rpmc_pkg::PORT_RST_VAL;
      o_port_od     <= 1'b1;
      o_weak_pullup <= 1'b1;
      o_wdt_div     <= rpmc_pkg::WDT_DIV_RST;
    end else begin
      o_ram_keep    <= !(state_r inside {rpmc_pkg::RPMC_POR_HOLD, rpmc_pkg::RPMC_POR_DELAY});
      o_rst_pin_o   <= 1'b0;
      o_pc_vector   <= rpmc_pkg::RESET_VECTOR;
      o_clk_sel_int <= o_clk_sel_int || o_sys_reset;
      o_port_latch  <= rpmc_pkg::PORT_RST_VAL;
      o_port_od     <= o_sys_reset;
      o_weak_pullup <= 1'b1;
      o_wdt_div     <= rpmc_pkg::WDT_DIV_RST;
    end
  end
endmodule : rpmc_ctrl
`default_nettype wire

// file: verification/rpmc_ctrl_properties.sv
// port checker for the reset and power mode controller
// assumes it is bound onto rpmc_ctrl, everything in the i_ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module rpmc_checker (
  input wire logic                   i_ref_clk,
  input wire logic                   i_reset,
  input wire rpmc_pkg::rpmc_sfr_req_t i_sfr,
  input wire logic                   i_supply_above,
  input wire logic                   i_rst_pin_i,
  input wire logic                   i_other_reset,
  input wire logic                   i_irq_pending,
  input wire logic                   o_rst_pin_o,
  input wire logic                   o_rst_pin_oe,
  input wire logic                   o_sys_reset,
  input wire logic                   o_cpu_clk_en,
  input wire logic                   o_osc_en,
  input wire logic                   o_periph_clk_en,
  input wire logic                   o_int_timer_dis,
  input wire logic                   o_pc_load,
  input wire logic                   o_sp_reinit,
  input wire logic                   o_ram_keep,
  input wire logic [7:0]             o_port_latch,
  input wire logic                   o_port_od,
  input wire logic                   o_weak_pullup,
  input wire logic                   o_wdt_enable,
  input wire logic [3:0]             o_wdt_div
);
  // ==========================================================
  // monitor enable shadow, so a disabled monitor does not trip the drop check
  logic mon_on_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) mon_on_r <= 1'b1;
    else if (i_sfr.wr && i_sfr.addr == rpmc_pkg::SMC_ADDR) mon_on_r <= i_sfr.wdata[rpmc_pkg::SMC_EN_BIT];
  end
  // selection shadow; an enabled but unselected monitor may not reset
  logic mon_pick_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) mon_pick_r <= 1'b1;
    else if (i_sfr.wr && i_sfr.addr == rpmc_pkg::RSR_ADDR) mon_pick_r <= i_sfr.wdata[rpmc_pkg::RSR_PORF_BIT];
  end
  // ==========================================================
  // assertions
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  reset_state_a: assert property (o_sys_reset |-> o_int_timer_dis && !o_cpu_clk_en && o_port_latch == 8'hFF)
    else $error("reset does not halt cpu and ports");
  reset_follow_a: assert property (o_sys_reset |=> o_sp_reinit && o_port_od && o_weak_pullup)
    else $error("stack or port state missing after reset");
  pin_drive_a: assert property (o_rst_pin_oe |-> o_sys_reset && !o_rst_pin_o)
    else $error("pin driven outside reset");
  pin_cause_a: assert property ($rose(o_rst_pin_oe) |-> $past(i_supply_above) == 1'b0)
    else $error("pin driven without a supply drop");
  pin_quiet_a: assert property ($fell(i_rst_pin_i) && i_supply_above && !o_sys_reset
    |=> o_sys_reset && !o_rst_pin_oe)
    else $error("pin reset handled wrongly");
  exit_load_a: assert property ($fell(o_sys_reset) |-> ##[0:1] (o_pc_load && o_wdt_enable && o_wdt_div == 4'hC))
    else $error("reset exit without vector load or watchdog");
  idle_clk_a: assert property (!o_cpu_clk_en && o_osc_en && !o_sys_reset |-> o_periph_clk_en)
    else $error("idle stops peripheral clock");
  idle_wake_a: assert property (!o_cpu_clk_en && o_periph_clk_en && !o_sys_reset && i_irq_pending |=> o_cpu_clk_en)
    else $error("interrupt does not end idle");
  stop_hold_a: assert property (!o_osc_en && !o_sys_reset && i_rst_pin_i && !i_other_reset && i_supply_above
    |=> !o_osc_en && o_int_timer_dis)
    else $error("stop left without reset");
  mon_reset_a: assert property (!i_supply_above && mon_on_r && mon_pick_r && !o_sys_reset
    |=> o_sys_reset && o_rst_pin_oe)
    else $error("supply drop not held in reset");
  mon_fast_a: assert property ($rose(i_supply_above) && o_ram_keep && o_rst_pin_oe && i_rst_pin_i && !i_other_reset
    |-> ##[1:2] !o_sys_reset)
    else $error("monitor release delayed");
  // main scenarios reached
  cover property (!o_cpu_clk_en && o_periph_clk_en && !o_sys_reset);
  cover property (!o_osc_en && !o_sys_reset);
  cover property (o_rst_pin_oe && o_ram_keep);
endmodule : rpmc_checker
bind rpmc_ctrl rpmc_checker rpmc_checker_i (.i_ref_clk, .i_reset, .i_sfr, .i_supply_above, .i_rst_pin_i,
  .i_other_reset, .i_irq_pending, .o_rst_pin_o, .o_rst_pin_oe, .o_sys_reset, .o_cpu_clk_en, .o_osc_en,
  .o_periph_clk_en, .o_int_timer_dis, .o_pc_load, .o_sp_reinit, .o_ram_keep, .o_port_latch, .o_port_od,
  .o_weak_pullup, .o_wdt_enable, .o_wdt_div);
`default_nettype wire

// file: verification/tb_reset_and_power_mode_control.sv
// self-checking bench for the reset and power mode controller
// assumes a shortened power-on delay; inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_reset_and_power_mode_control;
  localparam int DLY = 20;  // short delay keeps the run brief
  logic i_ref_clk = 0, i_reset = 1, i_supply_above = 0, i_rst_pin_i = 1, i_other_reset = 0, i_irq_pending = 0;
  rpmc_pkg::rpmc_sfr_req_t i_sfr = '0;
  logic [7:0]  o_sfr_rdata, o_port_latch;
  logic [15:0] o_pc_vector;
  logic [3:0]  o_wdt_div;
  logic o_rst_pin_o, o_rst_pin_oe, o_sys_reset, o_cpu_clk_en, o_osc_en, o_periph_clk_en, o_int_timer_dis;
  logic o_pc_load, o_sp_reinit, o_ram_keep, o_clk_sel_int, o_port_od, o_weak_pullup, o_wdt_enable;
  int err_total = 0, checked = 0, cyc = 0;
  rpmc_ctrl #(.POR_DELAY(DLY)) rpmc_ctrl_i (.i_ref_clk, .i_reset, .i_sfr, .o_sfr_rdata, .i_supply_above,
    .i_rst_pin_i, .i_other_reset, .i_irq_pending, .o_rst_pin_o, .o_rst_pin_oe, .o_sys_reset, .o_cpu_clk_en,
    .o_osc_en, .o_periph_clk_en, .o_int_timer_dis, .o_pc_load, .o_pc_vector, .o_sp_reinit, .o_ram_keep,
    .o_clk_sel_int, .o_port_latch, .o_port_od, .o_weak_pullup, .o_wdt_enable, .o_wdt_div);
  // ==========================================================
  // clock and hang guard
  initial forever #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      $display("Error %0t: timeout", $time);
      summarize();
    end
  end
  // ==========================================================
  // shared tasks
  task tick(int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // idle cycle after each access so strobes never toggle twice in one step
  task wr(logic [7:0] a, logic [7:0] d);
    i_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    i_sfr = '0;
    tick(1);
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    i_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    i_sfr = '0;
    tick(1);
    chk(16'(o_sfr_rdata & m), 16'(e));
  endtask : rd
  // bounded wait for reset entry, then for its release
  task wait_rst;
    int n;
    n = 0;
    while (o_sys_reset !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(16'(o_sys_reset), 16'h0001);
    while (o_sys_reset !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    chk(16'(o_sys_reset), 16'h0000);
  endtask : wait_rst
  // ==========================================================
  // scenarios
  task t_por;
    int n;
    n = 0;
    tick(2);
    i_reset = 0;
    tick(5);
    chk(16'({o_rst_pin_oe, o_sys_reset, o_ram_keep}), 16'h0006);
    i_supply_above = 1;
    while (o_sys_reset !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    chk(16'(n >= DLY && n <= DLY + 3), 16'h0001);
    chk(o_pc_vector, 16'h0000);
    chk(16'(o_clk_sel_int), 16'h0001);
    rd(rpmc_pkg::PMC_ADDR, 8'hFF, 8'h00);
    rd(rpmc_pkg::RSR_ADDR, 8'h02, 8'h02);
    rd(rpmc_pkg::SMC_ADDR, 8'hC0, 8'hC0);
    $display("power-up test done");
  endtask : t_por
  task t_idle;
    wr(rpmc_pkg::PMC_ADDR, 8'hFC);
    rd(rpmc_pkg::PMC_ADDR, 8'hFF, 8'hFC);
    wr(rpmc_pkg::PMC_ADDR, 8'hA9);
    chk(16'({o_cpu_clk_en, o_periph_clk_en, o_osc_en}), 16'h0003);
    rd(rpmc_pkg::PMC_ADDR, 8'hFF, 8'hA8);
    i_irq_pending = 1;
    tick(2);
    chk(16'(o_cpu_clk_en), 16'h0001);
    i_irq_pending = 0;
    $display("idle test done");
  endtask : t_idle
  task t_stop;
    wr(rpmc_pkg::PMC_ADDR, 8'h03);
    chk(16'({o_osc_en, o_int_timer_dis, o_cpu_clk_en}), 16'h0002);
    i_irq_pending = 1;
    tick(3);
    chk(16'(o_osc_en), 16'h0000);
    i_irq_pending = 0;
    i_other_reset = 1;
    tick(2);
    chk(16'({o_sys_reset, o_rst_pin_oe}), 16'h0002);
    i_other_reset = 0;
    wait_rst();
    rd(rpmc_pkg::PMC_ADDR, 8'hFF, 8'h00);
    rd(rpmc_pkg::RSR_ADDR, 8'h02, 8'h00);
    $display("stop test done");
  endtask : t_stop
  task t_mon;
    wr(rpmc_pkg::RSR_ADDR, 8'h02);
    i_supply_above = 0;
    tick(2);
    chk(16'({o_sys_reset, o_rst_pin_oe}), 16'h0003);
    i_supply_above = 1;
    tick(2);
    chk(16'({o_sys_reset, o_ram_keep}), 16'h0001);
    rd(rpmc_pkg::RSR_ADDR, 8'h02, 8'h02);
    $display("monitor test done");
  endtask : t_mon
  task t_soft;
    wr(rpmc_pkg::SMC_ADDR, 8'h00);
    wr(rpmc_pkg::RSR_ADDR, 8'h10);
    wait_rst();
    rd(rpmc_pkg::SMC_ADDR, 8'h80, 8'h00);
    rd(rpmc_pkg::RSR_ADDR, 8'h02, 8'h00);
    i_supply_above = 0;
    tick(3);
    chk(16'(o_sys_reset), 16'h0000);
    i_supply_above = 1;
    rd(8'h55, 8'hFF, 8'h00);
    wr(rpmc_pkg::SMC_ADDR, 8'h80);
    tick(2);
    wr(rpmc_pkg::RSR_ADDR, 8'h02);
    i_rst_pin_i = 0;
    tick(2);
    chk(16'({o_sys_reset, o_rst_pin_oe}), 16'h0002);
    i_rst_pin_i = 1;
    wait_rst();
    $display("software and pin reset test done");
  endtask : t_soft
  task summarize;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // ==========================================================
  // main sequence
  initial begin
    t_por();
    t_idle();
    t_stop();
    t_mon();
    t_soft();
    summarize();
  end
endmodule : tb_reset_and_power_mode_control
`default_nettype wire
